/* logic/ulsm_defs.vh */
`ifndef ULSM_DEFS_VH
`define ULSM_DEFS_VH
// register indices inside the uart register space
`define ULSM_ADDR_LINE_STATUS   4'h5
`define ULSM_ADDR_MODEM_CONTROL 4'h4
// line status bit positions
`define ULSM_LS_FIFO_ERR  7
`define ULSM_LS_TX_EMPTY  6
`define ULSM_LS_HOLD_EMPTY 5
`define ULSM_LS_BREAK     4
`define ULSM_LS_FRAMING   3
`define ULSM_LS_PARITY    2
`define ULSM_LS_OVERRUN   1
`define ULSM_LS_DATA      0
// modem control bit positions
`define ULSM_MC_PRESCALE  7
`define ULSM_MC_IRDA      6
`define ULSM_MC_XON_ANY   5
`define ULSM_MC_LOOPBACK  4
`define ULSM_MC_CTRL_TRIG 2
`define ULSM_MC_RTS       1
// writable mask: bits 3 and 0 are reserved
`define ULSM_MC_MASK      8'hf6
// bits guarded by the enhanced feature write enable
`define ULSM_MC_GUARDED   8'he4
`define ULSM_MC_RESET     8'h00
// receive fifo depth and pointer width
`define ULSM_FIFO_DEPTH   64
`define ULSM_PTR_W        6
`define ULSM_CNT_W        7
// prescaler count at which the tick fires when enabled (divide by four)
`define ULSM_PRESCALE_DIV 2'h3
`endif

/* logic/ulsm_flag_mem.v */
`default_nettype none
// receive fifo side store of error flags (break, framing, parity) per entry
module ulsm_flag_mem (
  input  wire       clk,
  input  wire       wr_en,
  input  wire [5:0] wr_addr,
  input  wire [2:0] wr_data,
  input  wire [5:0] rd_addr,
  output reg  [2:0] rd_data
);
  reg [2:0] mem [0:63];  // flag storage, no reset needed: validity tracked by counts

  // write port
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read of the entry at the given address
  always @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

/* logic/ulsm_top.v */
`default_nettype none
`include "ulsm_defs.vh"

// Functional notes
// [RL1] bit7 set while any error in fifo
// [RL2] bit6 set when holding and shift empty
// [RL3] bit5 set when transmit holding empty
// [RL4] bit4 break flag, stored character 0x00
// [RL5] bit3 framing error of head character
// [RL6] bit2 parity error of head character
// [RL7] bit1 set once overrun occurred
// [RL8] bit0 set when receive fifo nonempty
// [RL9] bits4:2 follow head of receive fifo
// [RL10] host reads status before holding register
// [RL11] bit7 selects clock divide by four
// [RL12] bit6 selects infrared line coding
// [RL13] bit5 enables xon any function
// [RL14] bit4 loops transmit and modem lines
// [RL15] bit2 opens control and trigger registers
// [RL16] bit1 drives request to send
// [RL17] guarded bits need enhanced write enable
// [RL18] reserved bits read zero
module ulsm_top (
  input  wire       CLK,
  input  wire       RESET,
  // register port from the serial host interface
  input  wire [3:0] REG_ADDR,
  input  wire       REG_WR,
  input  wire       REG_RD,
  input  wire [7:0] REG_WDATA,
  output reg  [7:0] REG_RDATA,
  input  wire       ENH_WRITE_EN,
  // receive fifo push from the receiver, pop from host reads
  input  wire       RX_PUSH,
  input  wire [7:0] RX_CHAR,
  input  wire       RX_BREAK,
  input  wire       RX_FRAMING,
  input  wire       RX_PARITY,
  input  wire       RX_POP,
  input  wire       RX_FIFO_RESET,
  output reg  [7:0] RX_STORE_CHAR,
  // transmitter state
  input  wire       TX_HOLD_EMPTY,
  input  wire       TX_SHIFT_EMPTY,
  // line pins and loopback
  input  wire       TX_LINE,
  input  wire       RX_PIN,
  output wire       RX_LINE,
  output wire       TX_PIN,
  input  wire       AUTO_RTS_EN,
  input  wire       AUTO_RTS_N,
  input  wire       CTS_PIN_N,
  output wire       RTS_N,
  output wire       CTS_STATUS,
  // mode outputs to the rest of the uart
  output wire       CLK_TICK,
  output wire       IRDA_MODE,
  output wire       XON_ANY,
  output wire       LOOPBACK,
  output wire       CTRL_TRIG_ACCESS
);
  reg  [7:0] modem_control;        // software mode register
  reg        overrun;              // sticky overrun indication
  reg  [5:0] wr_ptr;               // flag store write pointer
  reg  [5:0] rd_ptr;               // flag store read pointer (head)
  reg  [6:0] count;                // entries in receive fifo
  reg  [6:0] err_count;            // entries holding any error
  reg  [1:0] prescale;             // divide-by-four counter
  wire [2:0] head_flags;           // break/framing/parity of head entry
  wire [2:0] mem_flags;            // registered read of the flag store
  reg        head_byp;             // head entry was written in the cycle it was read
  reg  [2:0] head_byp_flags;       // flags of that freshly written head entry
  wire       do_push;              // accepted push
  wire       do_pop;               // accepted pop
  wire       push_err;             // pushed entry carries an error
  wire       pop_err;              // popped entry carried an error
  wire [7:0] line_status;          // assembled status byte
  wire [7:0] mc_keep;              // bits that this write must preserve
  wire [5:0] next_rd_ptr;          // head address after this cycle

  // error flags sit next to each fifo entry
  ulsm_flag_mem u_flags (
    .clk     (CLK),
    .wr_en   (do_push),
    .wr_addr (wr_ptr),
    .wr_data ({RX_BREAK, RX_FRAMING, RX_PARITY}),
    .rd_addr (next_rd_ptr),
    .rd_data (mem_flags)
  );

  // the store reads before it writes, so a push landing on the head address
  // would show stale flags for one cycle; forward the pushed flags instead
  always @(posedge CLK) begin
    if (RESET) begin
      head_byp       <= 1'b0;
      head_byp_flags <= 3'h0;
    end else begin
      head_byp       <= do_push && (wr_ptr == next_rd_ptr); // RL9
      head_byp_flags <= {RX_BREAK, RX_FRAMING, RX_PARITY};
    end
  end
  assign head_flags = head_byp ? head_byp_flags : mem_flags; // RL9

  // a push on a full fifo is lost and recorded as overrun
  assign do_push     = RX_PUSH && (count != `ULSM_FIFO_DEPTH);
  assign do_pop      = RX_POP && (count != 7'h00);
  assign push_err    = RX_BREAK | RX_FRAMING | RX_PARITY;
  assign pop_err     = |head_flags;
  // read address runs one ahead so the registered head is current
  assign next_rd_ptr = do_pop ? rd_ptr + 6'h01 : rd_ptr;

  // fifo bookkeeping for data presence and error accumulation
  always @(posedge CLK) begin
    if (RESET || RX_FIFO_RESET) begin
      wr_ptr    <= 6'h00;
      rd_ptr    <= 6'h00;
      count     <= 7'h00;
      err_count <= 7'h00;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 6'h01;
      end
      rd_ptr <= next_rd_ptr;
      count  <= count + {6'h00, do_push} - {6'h00, do_pop};
      // error entries counted in and out so bit7 clears only at zero
      err_count <= err_count + {6'h00, do_push & push_err}
                   - {6'h00, do_pop & pop_err}; // RL1
    end
  end

  // overrun holds until a status read; a new overrun in the read cycle wins
  always @(posedge CLK) begin
    if (RESET) begin
      overrun <= 1'b0;
    end else if (RX_PUSH && (count == `ULSM_FIFO_DEPTH)) begin
      overrun <= 1'b1; // RL7
    end else if (REG_RD && REG_ADDR == `ULSM_ADDR_LINE_STATUS) begin
      overrun <= 1'b0;
    end
  end

  // character handed to the receive store; a break forces zero data
  always @(posedge CLK) begin
    if (RESET) begin
      RX_STORE_CHAR <= 8'h00;
    end else if (RX_PUSH) begin
      RX_STORE_CHAR <= RX_BREAK ? 8'h00 : RX_CHAR; // RL4
    end
  end

  // status byte; head flags only meaningful while data is present
  assign line_status[`ULSM_LS_FIFO_ERR]  = (err_count != 7'h00);          // RL1
  assign line_status[`ULSM_LS_TX_EMPTY]  = TX_HOLD_EMPTY & TX_SHIFT_EMPTY; // RL2
  assign line_status[`ULSM_LS_HOLD_EMPTY] = TX_HOLD_EMPTY;                 // RL3
  assign line_status[`ULSM_LS_BREAK]     = (count != 7'h00) & head_flags[2]; // RL4 RL9
  assign line_status[`ULSM_LS_FRAMING]   = (count != 7'h00) & head_flags[1]; // RL5 RL9
  assign line_status[`ULSM_LS_PARITY]    = (count != 7'h00) & head_flags[0]; // RL6 RL9
  assign line_status[`ULSM_LS_OVERRUN]   = overrun;                        // RL7
  assign line_status[`ULSM_LS_DATA]      = (count != 7'h00);               // RL8

  // guarded bits are kept unless the enhanced write enable is set
  assign mc_keep = ENH_WRITE_EN ? 8'h00 : `ULSM_MC_GUARDED; // RL17

  // modem control write; reserved bits masked to zero
  always @(posedge CLK) begin
    if (RESET) begin
      modem_control <= `ULSM_MC_RESET;
    end else if (REG_WR && REG_ADDR == `ULSM_ADDR_MODEM_CONTROL) begin
      modem_control <= ((REG_WDATA & ~mc_keep) | (modem_control & mc_keep))
                       & `ULSM_MC_MASK; // RL17 RL18
    end
  end

  // register read data, registered; unmapped addresses read zero
  always @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `ULSM_ADDR_LINE_STATUS:   REG_RDATA <= line_status;
        `ULSM_ADDR_MODEM_CONTROL: REG_RDATA <= modem_control & `ULSM_MC_MASK; // RL18
        default:                  REG_RDATA <= 8'h00;
      endcase
    end
  end

  // input prescaler: tick every cycle or every fourth cycle
  always @(posedge CLK) begin
    if (RESET) begin
      prescale <= 2'h0;
    end else if (modem_control[`ULSM_MC_PRESCALE]) begin
      prescale <= prescale + 2'h1; // RL11
    end else begin
      prescale <= 2'h0;
    end
  end
  assign CLK_TICK = ~modem_control[`ULSM_MC_PRESCALE]
                    | (prescale == `ULSM_PRESCALE_DIV); // RL11

  assign IRDA_MODE      = modem_control[`ULSM_MC_IRDA];    // RL12
  assign XON_ANY        = modem_control[`ULSM_MC_XON_ANY]; // RL13
  assign LOOPBACK       = modem_control[`ULSM_MC_LOOPBACK];
  assign CTRL_TRIG_ACCESS = modem_control[`ULSM_MC_CTRL_TRIG]; // RL15

  // loopback: transmit feeds receive, pin idles high, rts feeds cts status
  assign RX_LINE    = LOOPBACK ? TX_LINE : RX_PIN;  // RL14
  assign TX_PIN     = LOOPBACK ? 1'b1 : TX_LINE;    // RL14
  assign CTS_STATUS = LOOPBACK ? modem_control[`ULSM_MC_RTS] : ~CTS_PIN_N; // RL14 RL16
  // automatic flow control overrides manual rts; pin held inactive in loopback
  assign RTS_N = LOOPBACK ? 1'b1 :
                 AUTO_RTS_EN ? AUTO_RTS_N : ~modem_control[`ULSM_MC_RTS]; // RL16
endmodule
`default_nettype wire

/* sim/ulsm_sva.sv */
`default_nettype none
`include "ulsm_defs.vh"
// port level checks on modem control writes, rts and the stored receive character
module ulsm_sva (
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic [3:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       ENH_WRITE_EN,
  input wire logic       RX_PUSH,
  input wire logic [7:0] RX_CHAR,
  input wire logic       RX_BREAK,
  input wire logic [7:0] RX_STORE_CHAR,
  input wire logic       AUTO_RTS_EN,
  input wire logic       RTS_N,
  input wire logic       CLK_TICK,
  input wire logic       IRDA_MODE,
  input wire logic       XON_ANY,
  input wire logic       LOOPBACK,
  input wire logic       CTRL_TRIG_ACCESS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // write strobe aimed at modem control
  wire mc_wr = REG_WR && REG_ADDR == `ULSM_ADDR_MODEM_CONTROL;
  wire [2:0] modes = {IRDA_MODE, XON_ANY, CTRL_TRIG_ACCESS};
  chk_mode_write: assert property (mc_wr && ENH_WRITE_EN |=>
    modes == {$past(REG_WDATA[6:5]), $past(REG_WDATA[2])}) else $error("mode bits not taken");
  chk_guard_hold: assert property (mc_wr && !ENH_WRITE_EN |=> $stable(modes))
    else $error("guarded bits changed");
  chk_loop_write: assert property (mc_wr |=> LOOPBACK == $past(REG_WDATA[4]))
    else $error("loopback bit not taken");
  chk_rts_manual: assert property (mc_wr && !REG_WDATA[4] && !AUTO_RTS_EN |=>
    AUTO_RTS_EN || RTS_N == !$past(REG_WDATA[1])) else $error("rts level wrong");
  chk_rts_loop: assert property (LOOPBACK |-> RTS_N) else $error("rts low in loopback");
  chk_break_char: assert property (RX_PUSH |=>
    RX_STORE_CHAR == ($past(RX_BREAK) ? 8'h00 : $past(RX_CHAR))) else $error("stored char wrong");
  chk_tick_full: assert property (mc_wr && ENH_WRITE_EN && !REG_WDATA[7] |=> CLK_TICK)
    else $error("clock tick divided");
  chk_reserved_zero: assert property (REG_RD && REG_ADDR == 4'h4 |=>
    !REG_RDATA[3] && !REG_RDATA[0]) else $error("reserved bit set");
endmodule
bind ulsm_top ulsm_sva chk (.CLK, .RESET, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA,
  .REG_RDATA, .ENH_WRITE_EN, .RX_PUSH, .RX_CHAR, .RX_BREAK, .RX_STORE_CHAR, .AUTO_RTS_EN,
  .RTS_N, .CLK_TICK, .IRDA_MODE, .XON_ANY, .LOOPBACK, .CTRL_TRIG_ACCESS);
`default_nettype wire

/* sim/ulsm_host.sv */
`default_nettype none
// host side: register accesses and receive holding reads
module ulsm_host (
  input wire logic       CLK,
  input wire logic [7:0] REG_RDATA,
  output var logic [3:0] REG_ADDR,
  output var logic       REG_WR,
  output var logic       REG_RD,
  output var logic [7:0] REG_WDATA,
  output var logic       RX_POP
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {REG_WR, REG_RD, RX_POP, REG_ADDR, REG_WDATA} = 15'h00f0;
  end
  // strobe held over exactly one taking edge; idle bus shows no stale data
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge CLK) #1;
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, wd};
    @(posedge CLK) #1;
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {2'b00, 4'hf, ~wd};
    rd = REG_RDATA;
  endtask
  // the bench calls this only after the status read of the same character
  task automatic pop();
    @(posedge CLK) #1 RX_POP = 1'b1;
    @(posedge CLK) #1 RX_POP = 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/ulsm_top_tb.sv */
`default_nettype none
`include "ulsm_defs.vh"
module ulsm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RESET, ENH_WRITE_EN, RX_PUSH, RX_BREAK, RX_FRAMING, RX_PARITY, RX_POP;
  logic RX_FIFO_RESET, TX_HOLD_EMPTY, TX_SHIFT_EMPTY, TX_LINE, RX_PIN, AUTO_RTS_EN;
  logic AUTO_RTS_N, CTS_PIN_N, REG_WR, REG_RD, RX_LINE, TX_PIN, RTS_N, CTS_STATUS;
  logic CLK_TICK, IRDA_MODE, XON_ANY, LOOPBACK, CTRL_TRIG_ACCESS, ov, lb;
  logic [3:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA, RX_CHAR, RX_STORE_CHAR, d, wd, mc;
  logic [2:0] q[$];
  integer seed = 88515, mismatches = 0, cmp_count = 0, i;
  ulsm_top uut (.CLK, .RESET, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
    .ENH_WRITE_EN, .RX_PUSH, .RX_CHAR, .RX_BREAK, .RX_FRAMING, .RX_PARITY, .RX_POP,
    .RX_FIFO_RESET, .RX_STORE_CHAR, .TX_HOLD_EMPTY, .TX_SHIFT_EMPTY, .TX_LINE, .RX_PIN,
    .RX_LINE, .TX_PIN, .AUTO_RTS_EN, .AUTO_RTS_N, .CTS_PIN_N, .RTS_N, .CTS_STATUS,
    .CLK_TICK, .IRDA_MODE, .XON_ANY, .LOOPBACK, .CTRL_TRIG_ACCESS);
  ulsm_host host (.CLK, .REG_RDATA, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .RX_POP);
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // status expected from the queued flags; head flags read zero when empty
  function automatic logic [7:0] exp_ls(input logic o);
    logic e;
    e = 1'b0;
    foreach (q[k]) e |= |q[k];
    return {e, TX_HOLD_EMPTY & TX_SHIFT_EMPTY, TX_HOLD_EMPTY,
            (q.size() != 0) ? q[0] : 3'h0, o, q.size() != 0};
  endfunction
  // guarded bits keep their value unless the write enable is high
  function automatic logic [7:0] exp_mc(input logic [7:0] o, w, input logic en);
    logic [7:0] g;
    g = en ? 8'h00 : `ULSM_MC_GUARDED;
    return (o & g) | (w & `ULSM_MC_MASK & ~g);
  endfunction
  initial begin
    {ENH_WRITE_EN, RX_PUSH, RX_CHAR, RX_BREAK, RX_FRAMING, RX_PARITY, RX_FIFO_RESET} = 0;
    {TX_HOLD_EMPTY, TX_SHIFT_EMPTY, TX_LINE, RX_PIN, AUTO_RTS_EN, AUTO_RTS_N} = 6'h3f;
    {RESET, CTS_PIN_N, mc} = 10'h300;
    repeat (5) @(posedge CLK);
    #1 RESET = 1'b0;
    host.acc(1'b0, 4'h4, 8'h00, d);
    chk("modem_control", 8'h00, d);
    host.acc(1'b0, 4'h9, 8'h00, d);
    chk("unmapped", 8'h00, d);
    // random writes, read back each one; line and rts inputs move meanwhile
    for (i = 0; i < 24; i++) begin
      wd = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      {ENH_WRITE_EN, TX_LINE, RX_PIN, AUTO_RTS_EN, AUTO_RTS_N, CTS_PIN_N} = 6'($random(seed));
      host.acc(1'b1, 4'h4, wd, d);
      mc = exp_mc(mc, wd, ENH_WRITE_EN);
      host.acc(1'b0, 4'h4, 8'h00, d);
      chk("modem_control", mc, d);
      chk("mode_outputs", {4'h0, mc[6:4], mc[2]},
          {4'h0, IRDA_MODE, XON_ANY, LOOPBACK, CTRL_TRIG_ACCESS});
      lb = mc[4];
      chk("line_pins", {4'h0, lb ? TX_LINE : RX_PIN, lb | TX_LINE, lb ? mc[1] : !CTS_PIN_N,
          lb | (AUTO_RTS_EN ? AUTO_RTS_N : !mc[1])},
          {4'h0, RX_LINE, TX_PIN, CTS_STATUS, RTS_N});
    end
    // fill the fifo and push once more to force an overrun
    for (i = 0; i < 65; i++) begin
      @(posedge CLK) #1;
      {RX_BREAK, RX_FRAMING, RX_PARITY} = (i % 9 == 4) ? 3'($random(seed)) : 3'h0;
      RX_CHAR = 8'($random(seed));
      RX_PUSH = 1'b1;
      if (i < 64) q.push_back({RX_BREAK, RX_FRAMING, RX_PARITY});
    end
    @(posedge CLK) #1 RX_PUSH = 1'b0;
    ov = 1'b1;
    // status first, then pop, so each flag belongs to the head character
    for (i = 0; i < 65; i++) begin
      {TX_HOLD_EMPTY, TX_SHIFT_EMPTY} = 2'($random(seed));
      host.acc(1'b0, 4'h5, 8'h00, d);
      chk("line_status", exp_ls(ov), d);
      ov = 1'b0;
      if (q.size() != 0) begin
        host.pop();
        void'(q.pop_front());
      end
    end
    // push straight into the empty fifo and read status one cycle later
    q.push_back(3'h1);
    @(posedge CLK) #1 {RX_PUSH, RX_PARITY} = 2'b11;
    fork
      host.acc(1'b0, 4'h5, 8'h00, d);
      begin @(posedge CLK) #1 {RX_PUSH, RX_PARITY} = 2'b00; end
    join
    chk("line_status", exp_ls(1'b0), d);
    // a fifo reset drops the entry together with its error
    @(posedge CLK) #1 RX_FIFO_RESET = 1'b1;
    @(posedge CLK) #1 RX_FIFO_RESET = 1'b0;
    q.delete();
    host.acc(1'b0, 4'h5, 8'h00, d);
    chk("line_status", exp_ls(1'b0), d);
    end_sim();
  end
  // hang guard, several times the expected run length
  initial begin
    repeat (3000) @(posedge CLK);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
